// file: design/smpg_pkg.sv
package smpg_pkg;

  ////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [7:0] SMC_IDX  = 8'h33;
  localparam logic [7:0] PRF_IDX  = 8'h64;
  localparam logic [7:0] PRS_IDX  = 8'h65;
  localparam logic [7:0] AUX_IDX  = 8'h70;
  localparam logic [7:0] STAT_IDX = 8'h71;

  // Reset values
  localparam logic [7:0] SMC_RST = 8'h00;
  localparam logic [7:0] PRF_RST = 8'h00;
  localparam logic [7:0] PRS_RST = 8'h00;
  localparam logic [7:0] AUX_RST = 8'h00;

  // Writable bit masks
  localparam logic [7:0] SMC_WMASK = 8'h0F;
  localparam logic [7:0] PRF_WMASK = 8'hEE;
  localparam logic [7:0] PRS_WMASK = 8'h3F;
  localparam logic [7:0] AUX_WMASK = 8'h1F;

  // Sleep control fields
  localparam int SMC_ARM_POS  = 0;
  localparam int SMC_MODE_LSB = 1;

  // First power reduction fields
  localparam int PRF_TWO_WIRE_POS  = 7;
  localparam int PRF_TIMER_TWO_POS = 6;
  localparam int PRF_TIMER_ZRO_POS = 5;
  localparam int PRF_TIMER_ONE_POS = 3;
  localparam int PRF_SER_PERI_POS  = 2;
  localparam int PRF_SER_PORT_POS  = 1;

  // Second power reduction fields
  localparam int PRS_KEYPAD_POS   = 5;
  localparam int PRS_CIPHER_POS   = 4;
  localparam int PRS_CARD_POS     = 3;
  localparam int PRS_FAST_SER_POS = 2;
  localparam int PRS_USB_DEV_POS  = 1;
  localparam int PRS_USB_HOST_POS = 0;

  // Auxiliary control fields
  localparam int AUX_T2_ASYNC_POS = 0;
  localparam int AUX_PLL_SEL_POS  = 1;
  localparam int AUX_PLL_PWR_POS  = 2;
  localparam int AUX_CONV_PWR_POS = 3;
  localparam int AUX_SCAN_DIS_POS = 4;

  // Status fields
  localparam int STAT_LOCK_POS  = 0;
  localparam int STAT_READY_POS = 1;
  localparam int STAT_DEACT_POS = 2;
  localparam int STAT_SLEEP_POS = 3;

  // Wake latencies in cycles
  localparam logic [15:0] FAST_WAKE_CYC = 16'h0006;
  localparam logic [15:0] IDLE_WAKE_CYC = 16'h0001;
  localparam logic [15:0] SLOW_WAKE_DEF = 16'h0010;

  typedef enum logic [2:0] {
    MODE_IDLE  = 3'b000,
    MODE_PDOWN = 3'b010,
    MODE_PSAVE = 3'b011,
    MODE_STBY  = 3'b110,
    MODE_XSTBY = 3'b111
  } smpg_mode_type;

  typedef enum logic [1:0] {
    FSM_RUN   = 2'b00,
    FSM_SLEEP = 2'b01,
    FSM_WAKE  = 2'b10
  } smpg_fsm_type;

  typedef struct packed {
    logic two_wire;
    logic timer_two;
    logic timer_zero;
    logic timer_one;
    logic serial_periph;
    logic serial_port;
    logic keypad;
    logic cipher;
    logic card_interface;
    logic fast_serial;
    logic usb_device;
    logic usb_host;
  } smpg_periph_type;

  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic asy;
    logic main_osc;
    logic timer_osc;
    logic watchdog;
  } smpg_clk_type;

endpackage

// file: design/smpg_sleep_power.sv
// Function
// (RULE1) Sleep control: bits 7..4 zero, 3..1 mode select, 0 arm bit, reset zero.
// (RULE2) Mode codes: 000 idle, 010 power-down, 011 save, 110 standby, 111 extended.
// (RULE3) Sleep instruction enters sleep only while arm bit is one.
// (RULE4) Software sets arm bit just before sleep and clears it after wake.
// (RULE5) First gating register: two-wire, timers 2/0/1, serial periph, serial port.
// (RULE6) Gating bit set stops that module's clock until cleared.
// (RULE7) Timer two gate acts only when its async select is zero.
// (RULE8) Ungated timers resume from their frozen state, no reinitialisation.
// (RULE9) Reserved bits of both gating registers read zero.
// (RULE10) Second gating register: keypad, cipher, card, fast serial, USB device, host.
// (RULE11) Software reinitialises communication modules after ungating.
// (RULE12) Gated USB host blocks USB cards; serial card path stays if ungated.
// (RULE13) Sleep never changes PLL select or converter power by itself.
// (RULE14) Software switches off PLL select, power, then waits lock zero.
// (RULE15) Clearing converter power starts deactivation until ready reads zero.
// (RULE16) Enabled brown-out detector stays active in every sleep mode.
// (RULE17) Enabled watchdog keeps running in every sleep mode.
// (RULE18) Voltage reference on whenever brown-out detection needs it.
// (RULE19) Debug enabled keeps main clock source running during sleep.
// (RULE20) Debug disabled by either fuse cleared or scan port disable bit.
// (RULE21) Idle stops CPU and flash clocks, peripherals and interrupts run.
// (RULE22) Standby modes resume six cycles after the wake condition.
// (RULE23) Gated peripheral frozen, its registers blocked; ungating restores it.
// (RULE24) Reserved mode code makes the sleep instruction a no-op.
// (RULE25) Writes to read-only or reserved bits ignored; they read zero.
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/100ps
module smpg_sleep_power
  import smpg_pkg::*;
#(
  parameter logic [15:0] SLOW_WAKE_CYC = smpg_pkg::SLOW_WAKE_DEF
) (
  input  wire logic                      i_core_clk,         // 200 MHz core clock
  input  wire logic                      i_rstn,             // Sync reset, low active
  input  wire logic [9:0]                i_avs_address,      // Byte address
  input  wire logic                      i_avs_read,         // Read request
  input  wire logic                      i_avs_write,        // Write request
  input  wire logic [31:0]               i_avs_writedata,    // Write data
  input  wire logic [3:0]                i_avs_byteenable,   // Byte lanes
  output logic [31:0]                    o_avs_readdata,     // Read data
  output logic                           o_avs_waitrequest,  // Stall
  input  wire logic                      i_sleep_instr,      // Sleep instruction pulse
  input  wire logic                      i_wake_req,         // Wake condition
  input  wire logic                      i_wdt_enable,       // Watchdog enabled
  input  wire logic                      i_pll_locked_flag,  // PLL lock pin
  input  wire logic                      i_converter_ready,  // Converter ready pin
  input  wire logic                      i_brownout_fuse,    // Brown-out fuse programmed
  input  wire logic                      i_debug_fuse,       // Debug fuse programmed
  input  wire logic                      i_scan_port_fuse,   // Scan fuse programmed
  output smpg_pkg::smpg_clk_type         o_clk_en,           // Clock domain enables
  output smpg_pkg::smpg_periph_type      o_periph_clk_en,    // Peripheral clocks
  output smpg_pkg::smpg_periph_type      o_periph_reg_en,    // Peripheral reg access
  output logic                           o_pll_output_select,// PLL mux select
  output logic                           o_pll_power,        // PLL on
  output logic                           o_converter_power,  // Converter on
  output logic                           o_converter_deact,  // Deactivation running
  output logic                           o_t2_async_select,  // Timer two async clock
  output logic                           o_bod_active,       // Brown-out detector on
  output logic                           o_vref_en,          // Voltage reference on
  output logic                           o_debug_enable,     // Debug system on
  output logic                           o_sleeping          // Core asleep
);

  import smpg_pkg::*;

  ////////////////////////////////////////////////////////////
  // State

  // One record of all flip-flops
  typedef struct packed {
    logic [4:0]      sync_m;
    logic [4:0]      sync_s;
    logic            waitreq;
    logic [31:0]     rdata;
    logic [7:0]      smc;
    logic [7:0]      prf;
    logic [7:0]      prs;
    logic [7:0]      aux;
    logic            deact;
    smpg_fsm_type    fsm;
    smpg_mode_type   cur;
    logic [15:0]     cnt;
    smpg_clk_type    clk_en;
    smpg_periph_type pclk;
    smpg_periph_type preg;
    logic            bod;
    logic            vref;
    logic            dbg;
    logic            slp;
  } smpg_state_type;

  smpg_state_type  s;
  smpg_state_type  next_s;

  // Combinational helpers
  logic            req;
  logic            wr;
  logic [7:0]      idx;
  logic [7:0]      rd_byte;
  logic [7:0]      wbyte;
  logic [7:0]      stat;
  logic [2:0]      sel;
  logic            mode_ok;
  logic [15:0]     wake_cyc;
  logic            asleep;
  logic            running;
  logic            as2;
  logic            bod_s;
  logic            dbg_on;
  smpg_periph_type gate;
  smpg_mode_type   m;

  ////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_s   = s;
    req      = i_avs_read | i_avs_write;
    idx      = i_avs_address[9:2];
    wbyte    = i_avs_writedata[7:0];
    wr       = 1'b0;
    rd_byte  = 8'h00;
    stat     = 8'h00;
    sel      = 3'b000;
    mode_ok  = 1'b0;
    wake_cyc = IDLE_WAKE_CYC;
    asleep   = 1'b0;
    running  = 1'b0;
    as2      = 1'b0;
    bod_s    = 1'b0;
    dbg_on   = 1'b0;
    gate     = '0;
    m        = MODE_IDLE;

    // Pin synchronisers
    // Fuses and flags: other domains
    next_s.sync_m = {i_scan_port_fuse, i_debug_fuse, i_brownout_fuse,
                     i_converter_ready, i_pll_locked_flag};
    // Only stage two reads stage one
    next_s.sync_s = s.sync_m;

    // Status view
    // Read-only snapshot
    stat[STAT_LOCK_POS]  = s.sync_s[0];
    stat[STAT_READY_POS] = s.sync_s[1];
    stat[STAT_DEACT_POS] = s.deact;
    stat[STAT_SLEEP_POS] = (s.fsm != FSM_RUN);

    // Read mux; unmapped reads return zero
    // Reserved bits masked
    if (i_avs_address[1:0] == 2'b00) begin
      case (idx)
        SMC_IDX: begin
          rd_byte = s.smc & SMC_WMASK;                    // RULE1 RULE25
        end
        PRF_IDX: begin
          rd_byte = s.prf & PRF_WMASK;                    // RULE9
        end
        PRS_IDX: begin
          rd_byte = s.prs & PRS_WMASK;                    // RULE9
        end
        AUX_IDX: begin
          rd_byte = s.aux & AUX_WMASK;
        end
        STAT_IDX: begin
          rd_byte = stat;
        end
        default: begin
          rd_byte = 8'h00;
        end
      endcase
    end

    // Avalon slave: one wait cycle, then the access completes
    // Each access takes two cycles
    next_s.waitreq = 1'b1;
    if (req && s.waitreq) begin
      next_s.waitreq = 1'b0;
      next_s.rdata   = {24'h00_0000, rd_byte};
    end
    // Lands at waitrequest low
    wr = i_avs_write && !s.waitreq && i_avs_byteenable[0]
         && (i_avs_address[1:0] == 2'b00);

    // Deactivation ends once ready is seen low
    // Set below wins
    if (s.deact && !s.sync_s[1]) begin
      next_s.deact = 1'b0;                                // RULE15
    end

    // Status and unmapped dropped
    if (wr) begin
      case (idx)
        SMC_IDX: begin
          next_s.smc = wbyte & SMC_WMASK;                 // RULE1 RULE25
        end
        PRF_IDX: begin
          next_s.prf = wbyte & PRF_WMASK;                 // RULE5 RULE25
        end
        PRS_IDX: begin
          next_s.prs = wbyte & PRS_WMASK;                 // RULE10 RULE25
        end
        AUX_IDX: begin
          next_s.aux = wbyte & AUX_WMASK;
          if (s.aux[AUX_CONV_PWR_POS] && !wbyte[AUX_CONV_PWR_POS]) begin
            next_s.deact = 1'b1;                          // RULE15
          end
        end
        default: begin
          next_s.aux = s.aux;
        end
      endcase
    end

    // Mode decode
    // Reserved codes inert
    sel = s.smc[SMC_MODE_LSB +: 3];
    case (sel)
      MODE_IDLE, MODE_PDOWN, MODE_PSAVE, MODE_STBY, MODE_XSTBY: begin
        mode_ok = 1'b1;                                   // RULE2
      end
      default: begin
        mode_ok = 1'b0;                                   // RULE24
      end
    endcase

    // Latency of the mode left
    case (s.cur)
      MODE_STBY, MODE_XSTBY: begin
        wake_cyc = FAST_WAKE_CYC;                         // RULE22
      end

      MODE_PDOWN, MODE_PSAVE: begin
        wake_cyc = SLOW_WAKE_CYC;
      end

      default: begin
        wake_cyc = IDLE_WAKE_CYC;
      end
    endcase

    // Sleep sequencer
    // Counter holds cycles left
    case (s.fsm)
      FSM_RUN: begin
        // Arm bit left to software
        if (i_sleep_instr && s.smc[SMC_ARM_POS] && mode_ok) begin
          next_s.fsm = FSM_SLEEP;                         // RULE3 RULE24
          // Mode fixed at entry
          next_s.cur = smpg_mode_type'(sel);
        end
      end

      FSM_SLEEP: begin
        if (i_wake_req) begin
          // Idle resumes next edge
          if (wake_cyc <= IDLE_WAKE_CYC) begin
            next_s.fsm = FSM_RUN;
          end else begin
            next_s.fsm = FSM_WAKE;
            next_s.cnt = wake_cyc - IDLE_WAKE_CYC;        // RULE22
          end
        end
      end

      FSM_WAKE: begin
        // Main oscillator runs here
        if (s.cnt <= IDLE_WAKE_CYC) begin
          next_s.fsm = FSM_RUN;
        end else begin
          next_s.cnt = s.cnt - IDLE_WAKE_CYC;
        end
      end

      default: begin
        next_s.fsm = FSM_RUN;
      end
    endcase

    // Clock enables follow the next state so they line up with it
    m       = next_s.cur;
    running = (next_s.fsm == FSM_RUN);
    next_s.slp = !running;
    asleep  = (next_s.fsm == FSM_SLEEP);
    as2     = next_s.aux[AUX_T2_ASYNC_POS];
    // Detector ignores sleep
    bod_s   = s.sync_s[2];
    dbg_on  = s.sync_s[3] && s.sync_s[4] && !next_s.aux[AUX_SCAN_DIS_POS];  // RULE20

    next_s.clk_en.cpu      = running;                     // RULE21
    next_s.clk_en.flash    = running;                     // RULE21
    next_s.clk_en.io       = running || (m == MODE_IDLE); // RULE21
    // Async clock per timer two
    next_s.clk_en.asy      = !asleep || (m == MODE_IDLE) || (m == MODE_PSAVE)
                             || (m == MODE_XSTBY && as2);
    next_s.clk_en.main_osc = !asleep || (m == MODE_IDLE) || (m == MODE_STBY)
                             || (m == MODE_XSTBY) || dbg_on;  // RULE19
    // Timer oscillator needs async
    next_s.clk_en.timer_osc = as2 && (!asleep || (m == MODE_IDLE)
                              || (m == MODE_PSAVE) || (m == MODE_XSTBY));
    next_s.clk_en.watchdog = i_wdt_enable;                // RULE17

    // Gating bits
    // Timer two async escapes gate
    gate.two_wire       = next_s.prf[PRF_TWO_WIRE_POS];
    gate.timer_two      = next_s.prf[PRF_TIMER_TWO_POS] && !as2;  // RULE7
    gate.timer_zero     = next_s.prf[PRF_TIMER_ZRO_POS];
    gate.timer_one      = next_s.prf[PRF_TIMER_ONE_POS];
    gate.serial_periph  = next_s.prf[PRF_SER_PERI_POS];
    gate.serial_port    = next_s.prf[PRF_SER_PORT_POS];
    gate.keypad         = next_s.prs[PRS_KEYPAD_POS];
    gate.cipher         = next_s.prs[PRS_CIPHER_POS];
    gate.card_interface = next_s.prs[PRS_CARD_POS];
    gate.fast_serial    = next_s.prs[PRS_FAST_SER_POS];
    gate.usb_device     = next_s.prs[PRS_USB_DEV_POS];
    gate.usb_host       = next_s.prs[PRS_USB_HOST_POS];   // RULE12

    // Clock stop only; no reset reaches the module, so state holds
    // Access blocked while gated
    next_s.pclk = {12{next_s.clk_en.io}} & ~gate;         // RULE6 RULE8 RULE10 RULE23
    if (!gate.timer_two && as2) begin
      next_s.pclk.timer_two = next_s.clk_en.asy;          // RULE7
    end
    next_s.preg = ~gate;                                  // RULE23

    next_s.bod  = bod_s;                                  // RULE16
    next_s.vref = bod_s;                                  // RULE18
    next_s.dbg  = dbg_on;                                 // RULE20
  end

  ////////////////////////////////////////////////////////////
  // Registers

  // Run clocks, no gating
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      s         <= '0;
      s.waitreq <= 1'b1;
      s.smc     <= SMC_RST;
      s.prf     <= PRF_RST;
      s.prs     <= PRS_RST;
      s.aux     <= AUX_RST;
      s.fsm     <= FSM_RUN;
      s.cur     <= MODE_IDLE;
      // Timer oscillator off
      s.clk_en  <= 7'h7C;
      s.pclk    <= '1;
      s.preg    <= '1;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////
  // Outputs

  // Sleep leaves PLL and converter exactly as software set them
  assign o_pll_output_select = s.aux[AUX_PLL_SEL_POS];     // RULE13
  assign o_pll_power         = s.aux[AUX_PLL_PWR_POS];     // RULE13
  assign o_converter_power   = s.aux[AUX_CONV_PWR_POS];    // RULE13
  assign o_converter_deact   = s.deact;
  assign o_t2_async_select   = s.aux[AUX_T2_ASYNC_POS];
  assign o_avs_readdata      = s.rdata;
  assign o_avs_waitrequest   = s.waitreq;
  assign o_clk_en            = s.clk_en;
  assign o_periph_clk_en     = s.pclk;
  assign o_periph_reg_en     = s.preg;
  assign o_bod_active        = s.bod;
  assign o_vref_en           = s.vref;
  assign o_debug_enable      = s.dbg;
  // All outputs are flip-flop bits
  assign o_sleeping          = s.slp;

endmodule

// file: dv/smpg_sleep_power_chk.sv
`timescale 1ns/100ps
module smpg_sleep_power_chk (
  input wire logic                     i_core_clk,          // Clock
  input wire logic                     i_rstn,              // Reset
  input wire logic                     i_avs_read,          // Read
  input wire logic                     i_avs_write,         // Write
  input wire logic                     i_sleep_instr,       // Sleep pulse
  input wire logic                     i_wake_req,          // Wake
  input wire logic                     o_avs_waitrequest,   // Stall
  input wire smpg_pkg::smpg_clk_type    o_clk_en,            // Clocks
  input wire smpg_pkg::smpg_periph_type o_periph_clk_en,     // Periph clocks
  input wire smpg_pkg::smpg_periph_type o_periph_reg_en,     // Periph access
  input wire logic                     o_pll_output_select, // PLL mux
  input wire logic                     o_pll_power,         // PLL on
  input wire logic                     o_converter_power,   // Converter on
  input wire logic                     o_bod_active,        // Brown-out
  input wire logic                     o_vref_en,           // Reference
  input wire logic                     o_debug_enable,      // Debug
  input wire logic                     o_sleeping           // Asleep
);
  import smpg_pkg::*;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);
  ////////////////////////////////////////////////////////////
  a_bus_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("Bus access not answered after one wait state");
  // Timer two excluded, its clock may follow the async domain
  a_gate_stops: assert property ((o_periph_clk_en & ~o_periph_reg_en & 12'hBFF) == 12'h000)
    else $error("Gated peripheral still clocked");
  a_sleep_cpu_off: assert property (o_sleeping |-> !o_clk_en.cpu && !o_clk_en.flash)
    else $error("CPU or flash clock running while asleep");
  a_run_clocks: assert property (!o_sleeping |-> o_clk_en.cpu && o_clk_en.io)
    else $error("CPU or I/O clock stopped while running");
  a_debug_osc: assert property (o_sleeping && o_debug_enable |-> o_clk_en.main_osc)
    else $error("Main oscillator stopped with debug enabled");
  a_bod_vref: assert property (o_vref_en == o_bod_active)
    else $error("Reference does not follow brown-out detector");
  a_bod_kept: assert property ($rose(o_sleeping) |-> $stable(o_bod_active))
    else $error("Brown-out detector changed on sleep entry");
  a_wdt_kept: assert property ($rose(o_sleeping) |-> o_clk_en.watchdog == $past(o_clk_en.watchdog))
    else $error("Watchdog clock changed on sleep entry");
  a_pll_kept: assert property ($rose(o_sleeping) |->
    $stable({o_pll_output_select, o_pll_power, o_converter_power}))
    else $error("PLL or converter changed on sleep entry");
  a_sleep_cause: assert property ($rose(o_sleeping) |-> $past(i_sleep_instr))
    else $error("Sleep entered without sleep instruction");
  a_sleep_stands: assert property (o_sleeping && !i_wake_req |=> o_sleeping)
    else $error("Left sleep without wake condition");
endmodule
bind smpg_sleep_power smpg_sleep_power_chk u_chk (
  .i_core_clk, .i_rstn, .i_avs_read, .i_avs_write, .i_sleep_instr, .i_wake_req, .o_avs_waitrequest,
  .o_clk_en, .o_periph_clk_en, .o_periph_reg_en, .o_pll_output_select, .o_pll_power,
  .o_converter_power, .o_bod_active, .o_vref_en, .o_debug_enable, .o_sleeping
);

// file: dv/smpg_cpu_model.sv
`timescale 1ns/100ps
module smpg_cpu_model (
  input  wire logic i_core_clk,        // Clock
  input  wire logic i_rstn,            // Reset
  input  wire logic i_go,              // Issue sleep instruction
  input  wire logic i_slow,            // Slow analog answers
  input  wire logic i_pll_power,       // PLL on
  input  wire logic i_converter_power, // Converter on
  output logic      o_sleep_instr,     // Sleep pulse
  output logic      o_pll_locked_flag, // PLL lock
  output logic      o_converter_ready  // Converter ready
);
  logic [3:0] pll_cnt;
  logic [3:0] dc_cnt;
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_sleep_instr <= 1'b0;
      o_pll_locked_flag <= 1'b0;
      o_converter_ready <= 1'b0;
      pll_cnt <= 4'h0;
      dc_cnt <= 4'h0;
    end else begin
      // One-cycle pulse per request
      o_sleep_instr <= i_go && !o_sleep_instr;
      pll_cnt <= (i_pll_power == o_pll_locked_flag) ? 4'h0 : pll_cnt + 4'h1;
      dc_cnt <= (i_converter_power == o_converter_ready) ? 4'h0 : dc_cnt + 4'h1;
      if (pll_cnt == (i_slow ? 4'h7 : 4'h1)) o_pll_locked_flag <= i_pll_power;
      if (dc_cnt == (i_slow ? 4'h8 : 4'h1)) o_converter_ready <= i_converter_power;
    end
  end
endmodule

// file: dv/sleep_and_power_gating_test.sv
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
module sleep_and_power_gating_test;
  import smpg_pkg::*;
  localparam logic [15:0] SLOW = 16'h0002;
  logic            i_core_clk = 1'b0, i_rstn = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic [9:0]      i_avs_address = 10'h000;
  logic [31:0]     i_avs_writedata = 32'h0000_0000, o_avs_readdata, q;
  logic [3:0]      i_avs_byteenable = 4'h1;
  logic            i_wake_req = 1'b0, i_wdt_enable = 1'b1, go = 1'b0, slow = 1'b0;
  logic            i_brownout_fuse = 1'b0, i_debug_fuse = 1'b0, i_scan_port_fuse = 1'b0;
  logic            i_sleep_instr, i_pll_locked_flag, i_converter_ready, o_avs_waitrequest;
  logic            o_pll_output_select, o_pll_power, o_converter_power, o_converter_deact;
  logic            o_t2_async_select, o_bod_active, o_vref_en, o_debug_enable, o_sleeping;
  smpg_clk_type    o_clk_en;
  smpg_periph_type o_periph_clk_en, o_periph_reg_en;
  int              fails = 0, total_checks = 0, mdl [0:255];
  int              regs [5] = '{'h33, 'h64, 'h65, 'h70, 'h7E};
  int unsigned     seed = 65306;
  logic [31:0]     r;
  always #2.5 i_core_clk = ~i_core_clk;
  smpg_sleep_power #(.SLOW_WAKE_CYC(SLOW)) dut (
    .i_core_clk, .i_rstn, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
    .o_avs_readdata, .o_avs_waitrequest, .i_sleep_instr, .i_wake_req, .i_wdt_enable, .i_pll_locked_flag,
    .i_converter_ready, .i_brownout_fuse, .i_debug_fuse, .i_scan_port_fuse, .o_clk_en, .o_periph_clk_en,
    .o_periph_reg_en, .o_pll_output_select, .o_pll_power, .o_converter_power, .o_converter_deact,
    .o_t2_async_select, .o_bod_active, .o_vref_en, .o_debug_enable, .o_sleeping
  );
  smpg_cpu_model u_cpu (
    .i_core_clk, .i_rstn, .i_go(go), .i_slow(slow), .i_pll_power(o_pll_power),
    .i_converter_power(o_converter_power), .o_sleep_instr(i_sleep_instr),
    .o_pll_locked_flag(i_pll_locked_flag), .o_converter_ready(i_converter_ready)
  );
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int msk(input int i);
    case (i)
      'h33: return SMC_WMASK;
      'h64: return PRF_WMASK;
      'h65: return PRS_WMASK;
      'h70: return AUX_WMASK;
      default: return 0;
    endcase
  endfunction
  // Clock runs where gate bit is clear
  function automatic smpg_periph_type egate();
    logic [7:0] f;
    logic [7:0] s;
    f = mdl['h64];
    s = mdl['h65];
    return ~{f[7:5], f[3:1], s[5:0]};
  endfunction
  task automatic finish_test();
    if (fails == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [3:0] b);
    int n;
    n = 0;
    i_avs_address <= a;
    i_avs_writedata <= {24'h00_0000, d};
    i_avs_byteenable <= b;
    i_avs_read <= !w;
    i_avs_write <= w;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 16);
    if (n >= 16) begin
      fails++;
      finish_test();
    end
    q = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    @(posedge i_core_clk);
  endtask
  task automatic wreg(input int i, input logic [7:0] d);
    bus(1'b1, 10'(i * 4), d, 4'h1);
    mdl[i] = d & msk(i);
  endtask
  task automatic rchk(input int i);
    bus(1'b0, 10'(i * 4), 8'h00, 4'h1);
    `CHK(q, mdl[i])
  endtask
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      bus(1'b0, 10'h1C4, 8'h00, 4'h1);
      n++;
    end while (q[b] !== v && n < 40);
    `CHK(q[b], v)
    if (q[b] !== v) finish_test();
  endtask
  task automatic do_reset();
    i_rstn <= 1'b0;
    foreach (mdl[k]) mdl[k] = 0;
    repeat (6) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    @(posedge i_core_clk);
    foreach (regs[k]) rchk(regs[k]);
    `CHK(o_periph_clk_en, 12'hFFF)
  endtask
  task automatic sleep_cycle(input int m, input logic arm, input logic dbg);
    int n;
    logic ok;
    ok = arm && (m inside {0, 2, 3, 6, 7});
    wreg('h33, {4'h0, m[2:0], arm});
    go <= 1'b1;
    @(posedge i_core_clk);
    go <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    `CHK(o_sleeping, ok)
    if (ok) begin
      `CHK(o_clk_en.io, m == 0)
      `CHK(o_clk_en.asy, m == 0 || m == 3)
      `CHK(o_clk_en.main_osc, m == 0 || m > 5 || dbg)
      i_wake_req <= 1'b1;
      n = 0;
      do begin
        @(posedge i_core_clk);
        n++;
      end while (o_sleeping !== 1'b0 && n < 40);
      i_wake_req <= 1'b0;
      `CHK(n, (m == 0 ? 1 : m > 5 ? 6 : int'(SLOW)) + 1)
      if (n >= 40) finish_test();
      rchk('h33);
      wreg('h33, 8'h00);
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    repeat (4) foreach (regs[k]) begin
      r = xs();
      wreg(regs[k], r[7:0]);
      rchk(regs[k]);
    end
    wreg('h70, 8'h00);
    bus(1'b1, 10'h0CC, 8'h0F, 4'h0);
    bus(1'b1, 10'h0CD, 8'h0F, 4'h1);
    rchk('h33);
    repeat (6) begin
      r = xs();
      wreg('h64, r[7:0]);
      wreg('h65, r[15:8]);
      `CHK(o_periph_clk_en, egate())
      `CHK(o_periph_reg_en, egate())
    end
    wreg('h64, 8'h40);
    wreg('h70, 8'h01);
    `CHK(o_t2_async_select, 1'b1)
    `CHK(o_periph_clk_en.timer_two, 1'b1)
    wreg('h70, 8'h00);
    `CHK(o_periph_clk_en.timer_two, 1'b0)
    wreg('h64, 8'h00);
    `CHK(o_periph_clk_en.timer_two, 1'b1)
    for (int c = 0; c < 9; c++) sleep_cycle(c % 8, c < 8, 1'b0);
    slow = 1'b1;
    wreg('h70, 8'h0E);
    `CHK({o_pll_output_select, o_pll_power, o_converter_power}, 3'b111)
    poll(0, 1'b1);
    poll(1, 1'b1);
    sleep_cycle(2, 1'b1, 1'b0);
    wreg('h70, 8'h0C);
    wreg('h70, 8'h08);
    poll(0, 1'b0);
    wreg('h70, 8'h00);
    poll(2, 1'b1);
    `CHK(o_converter_deact, 1'b1)
    poll(1, 1'b0);
    repeat (4) @(posedge i_core_clk);
    poll(2, 1'b0);
    `CHK(o_converter_deact, 1'b0)
    i_brownout_fuse <= 1'b1;
    i_debug_fuse <= 1'b1;
    i_scan_port_fuse <= 1'b1;
    repeat (5) @(posedge i_core_clk);
    `CHK({o_bod_active, o_vref_en, o_debug_enable}, 3'b111)
    sleep_cycle(2, 1'b1, 1'b1);
    wreg('h70, 8'h10);
    repeat (2) @(posedge i_core_clk);
    `CHK(o_debug_enable, 1'b0)
    wreg('h70, 8'h00);
    i_scan_port_fuse <= 1'b0;
    repeat (5) @(posedge i_core_clk);
    `CHK(o_debug_enable, 1'b0)
    i_scan_port_fuse <= 1'b1;
    i_debug_fuse <= 1'b0;
    repeat (5) @(posedge i_core_clk);
    `CHK(o_debug_enable, 1'b0)
    wreg('h64, 8'hFF);
    do_reset();
    finish_test();
  end
endmodule
